// *** verification/tasm_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module tasm_props
(
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        CONV_BUSY,
  input wire logic [7:0]  LOCAL_TEMP,
  input wire logic [7:0]  LOCAL_HIGH_LIMIT,
  input wire logic [7:0]  REMOTE_TEMP,
  input wire logic [7:0]  CRITICAL_LIMIT,
  input wire logic [6:0]  CRIT_HYSTERESIS,
  input wire logic [15:0] TACH_COUNT,
  input wire logic [15:0] TACH_LIMIT,
  input wire logic        CRITICAL_SHUTDOWN_OUTPUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  wire st = REG_RD && REG_ADDR == 8'h02;
  wire mt = REG_RD && REG_ADDR == 8'h16;
  AST_MASK_FIXED: assert property (mt |=> REG_RDATA[7] && REG_RDATA[5] && REG_RDATA[2])
    else $error("mask fixed bits");
  AST_STAT_B5: assert property (st |=> !REG_RDATA[5])
    else $error("status bit 5");
  AST_POR_LOW: assert property (REG_RD && REG_ADDR == 8'h33 |=> REG_RDATA[6:0] == 7'h00)
    else $error("power status low bits");
  AST_BUSY: assert property (CONV_BUSY[*4] ##0 st |=> REG_RDATA[7])
    else $error("busy bit");
  AST_LOCAL_HI: assert property ((LOCAL_TEMP > LOCAL_HIGH_LIMIT)[*3] ##0 st |=> REG_RDATA[6])
    else $error("local flag");
  AST_TACH: assert property ((TACH_COUNT > TACH_LIMIT)[*3] ##0 st |=> REG_RDATA[0])
    else $error("tach flag");
  AST_CRIT_SET: assert property (REMOTE_TEMP > CRITICAL_LIMIT |-> ##[1:3] CRITICAL_SHUTDOWN_OUTPUT)
    else $error("shutdown not set");
  // Sum form avoids wrap when hysteresis exceeds the limit
  wire [8:0] hold_sum = {1'b0, REMOTE_TEMP} + {2'b00, CRIT_HYSTERESIS};
  AST_CRIT_HOLD: assert property (CRITICAL_SHUTDOWN_OUTPUT && hold_sum >= {1'b0, CRITICAL_LIMIT}
    |=> CRITICAL_SHUTDOWN_OUTPUT)
    else $error("shutdown dropped");
endmodule
bind tasm_top tasm_props u_props (.*);
`default_nettype wire

// *** verification/tasm_sensor.sv ***
`timescale 1ns/100ps
`default_nettype none
module tasm_sensor
(
  input  wire logic   lhi,
  input  wire logic   slow,
  output logic [7:0]  LOCAL_TEMP,
  output logic [7:0]  LOCAL_HIGH_LIMIT,
  output logic [7:0]  REMOTE_HIGH_LIMIT,
  output logic [7:0]  REMOTE_LOW_LIMIT,
  output logic [7:0]  CRITICAL_LIMIT,
  output logic [15:0] TACH_COUNT,
  output logic [15:0] TACH_LIMIT
);
  // Idle readings sit on the limit
  assign LOCAL_TEMP = lhi ? 8'h51 : 8'h50;
  assign LOCAL_HIGH_LIMIT = 8'h50;
  assign REMOTE_HIGH_LIMIT = 8'h60;
  assign REMOTE_LOW_LIMIT = 8'h20;
  assign CRITICAL_LIMIT = 8'h70;
  assign TACH_COUNT = 16'h1000;
  assign TACH_LIMIT = slow ? 16'h0FFF : 16'h1000;
endmodule
`default_nettype wire

// *** verification/test_thermal_alarm_status_mask.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_thermal_alarm_status_mask;
  logic        REF_CLK, RST_B, REG_RD, REG_WR, CONV_BUSY, DIODE_FAULT, ALERT_B, lhi, slow;
  logic        COMPARATOR_MODE_SELECT, CRITICAL_SHUTDOWN_OUTPUT;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, LOCAL_TEMP, LOCAL_HIGH_LIMIT, REMOTE_TEMP;
  logic [7:0]  REMOTE_HIGH_LIMIT, REMOTE_LOW_LIMIT, CRITICAL_LIMIT;
  logic [6:0]  CRIT_HYSTERESIS;
  logic [15:0] TACH_COUNT, TACH_LIMIT;
  logic [7:0]  fl [6] = '{8'h40, 8'h10, 8'h08, 8'h12, 8'h01, 8'h04};
  int          failures = 0, n_compared = 0;
  tasm_sensor u_sen (.*);
  tasm_top #(.INIT_CYCLES(4)) uut (.*);
  task end_sim;
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task c(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task wr(input logic [7:0] a, d);
    w(1);
    {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
    w(1);
    REG_WR = 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    w(1);
    {REG_ADDR, REG_RD} = {a, 1'b1};
    w(1);
    REG_RD = 1'b0;
    c(REG_RDATA, e);
  endtask
  task p(input logic [1:0] e);
    c({6'h00, ALERT_B, CRITICAL_SHUTDOWN_OUTPUT}, {6'h00, e});
  endtask
  task s(input int k, input logic on);
    case (k)
      0: lhi = on;
      1: REMOTE_TEMP = on ? 8'h61 : 8'h40;
      2: REMOTE_TEMP = on ? 8'h1F : 8'h40;
      3: REMOTE_TEMP = on ? 8'h71 : 8'h40;
      4: slow = on;
      default: DIODE_FAULT = on;
    endcase
  endtask
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    #20000;
    failures++;
    end_sim;
  end
  initial
  begin
    {RST_B, REG_RD, REG_WR, DIODE_FAULT, COMPARATOR_MODE_SELECT, lhi, slow} = 7'h00;
    {REG_ADDR, REG_WDATA, REMOTE_TEMP} = 24'h000040;
    CONV_BUSY = 1'b1;
    CRIT_HYSTERESIS = 7'h0A;
    w(8);
    RST_B = 1'b1;
    rd(8'h33, 8'h80);
    w(4);
    rd(8'h33, 8'h00);
    rd(8'h16, 8'hA4);
    wr(8'h16, 8'h5B);
    rd(8'h16, 8'hFF);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h80);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h16, 8'hA4);
      s(k, 1'b1);
      w(5);
      p({k == 5, k == 3});
      rd(8'h02, fl[k] | 8'h80);
      wr(8'h16, fl[k]);
      w(2);
      p({1'b1, k == 3});
      s(k, 1'b0);
      w(5);
      rd(8'h02, fl[k] | 8'h80);
      rd(8'h02, 8'h80);
    end
    {CONV_BUSY, COMPARATOR_MODE_SELECT, lhi} = 3'b011;
    w(5);
    p(2'b00);
    lhi = 1'b0;
    w(5);
    p(2'b10);
    COMPARATOR_MODE_SELECT = 1'b0;
    w(3);
    p(2'b00);
    rd(8'h02, 8'h40);
    // Fully masked: shutdown must still act
    wr(8'h16, 8'hFF);
    REMOTE_TEMP = 8'h71;
    w(5);
    REMOTE_TEMP = 8'h66;
    w(5);
    p(2'b11);
    REMOTE_TEMP = 8'h65;
    w(5);
    p(2'b10);
    // Mid-run reset with a live alarm and a full mask
    lhi = 1'b1;
    w(3);
    RST_B = 1'b0;
    w(2);
    p(2'b10);
    RST_B = 1'b1;
    rd(8'h33, 8'h80);
    rd(8'h16, 8'hA4);
    lhi = 1'b0;
    end_sim;
  end
endmodule
`default_nettype wire

// *** verilog/tasm_crit_hold.v ***
`timescale 1ns/100ps
`default_nettype none
module tasm_crit_hold
(
  input  wire       REF_CLK,
  input  wire       RST_B,
  input  wire [7:0] remote_temp,
  input  wire [7:0] critical_limit,
  input  wire [6:0] hysteresis,
  output reg        active
);
  wire [8:0] release_level;

  // Guard against limit below hysteresis: floor at zero
  assign release_level = ({1'b0, critical_limit} > {2'b00, hysteresis}) ?
                         ({1'b0, critical_limit} - {2'b00, hysteresis}) : 9'h000;

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      active <= 1'b0;
    else if (remote_temp > critical_limit)
      active <= 1'b1;
    else if ({1'b0, remote_temp} < release_level)
      active <= 1'b0;
  end
endmodule
`default_nettype wire

// *** verilog/tasm_defines.vh ***
// Behaviour
// - Alarm flags latch; clear on read if gone
// - Status bit 7 shows converting, no alert
// - Bit 6 local over high limit, alerts
// - Status bit 5 always reads zero
// - Bit 4 remote over high limit, alerts
// - Bit 3 remote under low limit, alerts
// - Bit 2 diode fault, no alert/critical
// - Bit 1 remote critical, alert and shutdown
// - Bit 0 tach count over limit, alerts
// - Mask bits 7,5,2 always read one
// - Mask bit 6 blocks local over alarm
// - Mask bit 4 blocks remote over alarm
// - Mask bit 3 blocks remote under alarm
// - Mask bit 1 blocks remote critical alarm
// - Mask bit 0 blocks fan slow alarm
// - Power status bit 7 init busy, rest zero
// - Comparator mode: alert follows live conditions
// - Shutdown holds until below limit minus hysteresis
`ifndef TASM_DEFINES_VH
`define TASM_DEFINES_VH
`define TASM_ADDR_STATUS   8'h02
`define TASM_ADDR_MASK     8'h16
`define TASM_ADDR_POR      8'h33
`define TASM_BIT_BUSY      7
`define TASM_BIT_LOCAL_HI  6
`define TASM_BIT_REMOTE_HI 4
`define TASM_BIT_REMOTE_LO 3
`define TASM_BIT_FAULT     2
`define TASM_BIT_CRIT      1
`define TASM_BIT_TACH      0
`define TASM_MASK_FIXED    8'hA4
`define TASM_MASK_RESET    8'hA4
`define TASM_HYST_RESET    8'h0A
`define TASM_INIT_CYCLES   16
`endif

// *** verilog/tasm_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module tasm_sync
#(
  parameter WIDTH = 8
)
(
  input  wire             REF_CLK,
  input  wire             RST_B,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** verilog/tasm_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "tasm_defines.vh"
module tasm_top
#(
  parameter INIT_CYCLES = `TASM_INIT_CYCLES
)
(
  input  wire       REF_CLK,
  input  wire       RST_B,
  input  wire [7:0] REG_ADDR,
  input  wire       REG_RD,
  input  wire       REG_WR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  input  wire       CONV_BUSY,
  input  wire [7:0] LOCAL_TEMP,
  input  wire [7:0] LOCAL_HIGH_LIMIT,
  input  wire [7:0] REMOTE_TEMP,
  input  wire [7:0] REMOTE_HIGH_LIMIT,
  input  wire [7:0] REMOTE_LOW_LIMIT,
  input  wire [7:0] CRITICAL_LIMIT,
  input  wire [6:0] CRIT_HYSTERESIS,
  input  wire       DIODE_FAULT,
  input  wire [15:0] TACH_COUNT,
  input  wire [15:0] TACH_LIMIT,
  input  wire       COMPARATOR_MODE_SELECT,
  output reg        ALERT_B,
  output wire       CRITICAL_SHUTDOWN_OUTPUT
);
  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous flags from the analog side
  wire [1:0] sync_in;
  wire       busy;
  wire       fault;

  tasm_sync #(.WIDTH(2)) u_sync
  (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .d       ({CONV_BUSY, DIODE_FAULT}),
    .q       (sync_in)
  );

  assign busy  = sync_in[1];
  assign fault = sync_in[0];

  ////////////////////////////////////////////////////////////////////////////
  // Live conditions; comparisons are on same-clock converter results
  wire cond_local_hi;
  wire cond_remote_hi;
  wire cond_remote_lo;
  wire cond_crit;
  wire cond_tach;

  assign cond_local_hi  = LOCAL_TEMP > LOCAL_HIGH_LIMIT;
  assign cond_remote_hi = REMOTE_TEMP > REMOTE_HIGH_LIMIT;
  assign cond_remote_lo = REMOTE_TEMP < REMOTE_LOW_LIMIT;
  assign cond_crit      = REMOTE_TEMP > CRITICAL_LIMIT;
  assign cond_tach      = TACH_COUNT > TACH_LIMIT;

  wire [7:0] cond_vec;
  assign cond_vec = {1'b0, cond_local_hi, 1'b0, cond_remote_hi, cond_remote_lo,
                     fault, cond_crit, cond_tach};

  ////////////////////////////////////////////////////////////////////////////
  // Power-on initialisation timer
  reg [15:0] init_count;
  reg        init_in_progress;

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      init_count       <= 16'h0000;
      init_in_progress <= 1'b1;
    end
    else if (init_in_progress)
    begin
      if (init_count >= INIT_CYCLES - 1)
        init_in_progress <= 1'b0;
      else
        init_count <= init_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags and mask
  reg  [7:0] alarm_flags;
  reg  [7:0] mask_rw;
  wire [7:0] alarm_mask;
  wire       status_read;
  wire       mask_write;
  reg  [7:0] next_flags;

  assign status_read = REG_RD && (REG_ADDR == `TASM_ADDR_STATUS);
  assign mask_write  = REG_WR && (REG_ADDR == `TASM_ADDR_MASK);
  assign alarm_mask  = mask_rw | `TASM_MASK_FIXED;

  // New events win over the clearing read
  always @*
  begin
    next_flags = alarm_flags;
    if (status_read)
      next_flags = cond_vec;
    else
      next_flags = alarm_flags | cond_vec;
    next_flags[`TASM_BIT_BUSY] = 1'b0;
    next_flags[5]              = 1'b0;
  end

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      alarm_flags <= 8'h00;
      mask_rw     <= 8'h00;
    end
    else
    begin
      alarm_flags <= next_flags;
      if (mask_write)
        mask_rw <= REG_WDATA & ~`TASM_MASK_FIXED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the strobe
  wire [7:0] status_view;
  assign status_view = {busy, alarm_flags[6:0]};

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        `TASM_ADDR_STATUS: REG_RDATA <= status_view;
        `TASM_ADDR_MASK:   REG_RDATA <= alarm_mask;
        `TASM_ADDR_POR:    REG_RDATA <= {init_in_progress, 7'h00};
        default:           REG_RDATA <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert: busy and diode fault are excluded from the source set
  wire [7:0] alert_sources;
  wire [7:0] src_sel;
  wire       alert_now;

  assign src_sel = 8'h5B;
  assign alert_sources = COMPARATOR_MODE_SELECT ? cond_vec : alarm_flags;
  assign alert_now = |(alert_sources & src_sel & ~alarm_mask);

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ALERT_B <= 1'b1;
    else
      ALERT_B <= ~alert_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Critical shutdown ignores the mask and the diode fault
  tasm_crit_hold u_crit
  (
    .REF_CLK        (REF_CLK),
    .RST_B          (RST_B),
    .remote_temp    (REMOTE_TEMP),
    .critical_limit (CRITICAL_LIMIT),
    .hysteresis     (CRIT_HYSTERESIS),
    .active         (CRITICAL_SHUTDOWN_OUTPUT)
  );
endmodule
`default_nettype wire
